// ===== src/pmu_regs_pkg.sv
// register map, field layout, reset values, timing counts and helpers of the regulator control block
// assumes a 200 MHz core clock and a byte-level front end that has already decoded the serial bus
package pmu_regs_pkg;

    // register offsets
    localparam logic [7:0] SYS_CTRL_ADDR = 8'h07;
    localparam logic [7:0] OUT_EN_ADDR = 8'h10;
    localparam logic [7:0] OUT_STATUS_ADDR = 8'h11;
    localparam logic [7:0] VCHG_ADDR = 8'h20;
    localparam logic [7:0] B1_TV1_ADDR = 8'h23;

    // writable bits, fixed read-one bits and reset values
    localparam logic [7:0] SYS_CTRL_MASK = 8'h76;
    localparam logic [7:0] SYS_CTRL_FIXED = 8'h08;
    localparam logic [7:0] SYS_CTRL_RESET = 8'h20;
    localparam logic [7:0] OUT_EN_MASK = 8'h55;
    localparam logic [7:0] OUT_EN_RESET = 8'h55;
    localparam logic [7:0] VCHG_MASK = 8'h33;
    localparam logic [7:0] VCHG_RESET = 8'h00;
    localparam logic [7:0] B1_TV1_MASK = 8'h1F;
    localparam logic [7:0] B1_TV1_RESET = 8'h09;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // field positions
    localparam int DELAY_LSB = 4;
    localparam int EN_LDO2 = 6;
    localparam int EN_LDO1 = 4;
    localparam int EN_BUCK2 = 2;
    localparam int EN_BUCK1 = 0;
    localparam int ST_BUCKS = 7;
    localparam int ST_LDOS = 6;
    localparam int ST_LDO2 = 5;
    localparam int ST_LDO1 = 4;
    localparam int ST_BUCK2 = 2;
    localparam int ST_BUCK1 = 0;
    localparam int VC_B2_SEL = 5;
    localparam int VC_B2_RAMP = 4;
    localparam int VC_B1_SEL = 1;
    localparam int VC_B1_RAMP = 0;

    // delay table is kept in half-millisecond steps
    localparam int CLK_PERIOD_NS = 5;
    localparam int HALF_MS_NS = 500000;
    localparam int HALF_MS_CYCLES = HALF_MS_NS / CLK_PERIOD_NS;
    localparam logic [4:0] MAX_HALVES = 5'h16;

    // buck1 code map in millivolts
    localparam logic [4:0] B1_CODE_TOP = 5'h19;
    localparam logic [11:0] B1_MV_BASE = 12'h320;
    localparam logic [11:0] B1_MV_STEP = 12'h032;
    localparam logic [11:0] B1_MV_TOP = 12'h7D0;

    typedef struct packed {
        logic ldo2;
        logic ldo1;
        logic buck2;
        logic buck1;
    } rail_set_t;

    typedef struct packed {
        logic [4:0] ldo2;
        logic [4:0] ldo1;
        logic [4:0] buck2;
        logic [4:0] buck1;
    } rail_delay_t;

    // one byte event from the serial front end
    typedef struct packed {
        logic frame_start;
        logic byte_valid;
        logic [7:0] data;
        logic read_req;
    } host_byte_t;

    typedef enum logic [1:0] {IDLE_PHASE, POINTER_PHASE, DATA_PHASE} bus_phase_t;

    function automatic rail_delay_t delay_halves(input logic [2:0] code);
        unique case (code)
            3'h0: delay_halves = {5'h02, 5'h02, 5'h02, 5'h02};
            3'h1: delay_halves = {5'h04, 5'h04, 5'h03, 5'h02};
            3'h2: delay_halves = {5'h0C, 5'h06, 5'h04, 5'h03};
            3'h3: delay_halves = {5'h02, 5'h02, 5'h04, 5'h03};
            3'h4: delay_halves = {5'h0C, 5'h06, 5'h04, 5'h03};
            3'h5: delay_halves = {5'h04, 5'h04, 5'h03, 5'h03};
            3'h6: delay_halves = {5'h03, 5'h02, 5'h04, 5'h06};
            3'h7: delay_halves = {5'h16, 5'h0C, 5'h06, 5'h04};
        endcase
    endfunction

    function automatic logic [11:0] code_to_mv(input logic [4:0] code);
        if (code == 5'h00) begin
            code_to_mv = 12'h000;
        end else if (code > B1_CODE_TOP) begin
            code_to_mv = B1_MV_TOP;
        end else begin
            code_to_mv = 12'(B1_MV_BASE + B1_MV_STEP * 12'(code - 5'h01));
        end
    endfunction

endpackage

// ===== src/power_on_sequencer.sv
// staggered start of the four rails after the enable pin rises
// assumes the enable pin is already synchronous to core_clk_i
`timescale 1ns/100ps
`default_nettype none
module power_on_sequencer #(
    parameter int unsigned HALF_MS_CYCLES = pmu_regs_pkg::HALF_MS_CYCLES
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // control
    input wire logic enable_pin_i,
    input wire logic [2:0] delay_code_i,
    input wire pmu_regs_pkg::rail_set_t rail_enable_i,
    // rail start levels
    output pmu_regs_pkg::rail_set_t rail_run_o
);
    logic pin_q, pin_d;
    logic [2:0] code_q, code_d;
    logic [31:0] tick_q, tick_d;
    logic [4:0] halves_q, halves_d;
    pmu_regs_pkg::rail_set_t run_q, run_d;
    pmu_regs_pkg::rail_delay_t dly;

    always_comb begin
        pin_d = enable_pin_i;
        // code is frozen at the pin edge so a mid-sequence rewrite cannot reorder rails
        code_d = (enable_pin_i && !pin_q) ? delay_code_i : code_q;
        tick_d = tick_q;
        halves_d = halves_q;
        if (!pin_q) begin
            tick_d = 32'h0000_0000;
            halves_d = 5'h00;
        end else if (halves_q != pmu_regs_pkg::MAX_HALVES) begin
            if (tick_q == HALF_MS_CYCLES - 1) begin
                tick_d = 32'h0000_0000;
                halves_d = halves_q + 5'h01;
            end else begin
                tick_d = tick_q + 32'h0000_0001;
            end
        end
        dly = pmu_regs_pkg::delay_halves(code_q);
        run_d.buck1 = pin_q && rail_enable_i.buck1 && halves_q >= dly.buck1;
        run_d.buck2 = pin_q && rail_enable_i.buck2 && halves_q >= dly.buck2;
        run_d.ldo1 = pin_q && rail_enable_i.ldo1 && halves_q >= dly.ldo1;
        run_d.ldo2 = pin_q && rail_enable_i.ldo2 && halves_q >= dly.ldo2;
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pin_q <= 1'b0;
            code_q <= 3'h0;
            tick_q <= 32'h0000_0000;
            halves_q <= 5'h00;
            run_q <= 4'h0;
        end else begin
            pin_q <= pin_d;
            code_q <= code_d;
            tick_q <= tick_d;
            halves_q <= halves_d;
            run_q <= run_d;
        end
    end

    assign rail_run_o = run_q;

    chk_run_after_delay: assert property (@(posedge core_clk_i) disable iff (reset_i)
        $rose(run_q.ldo2) |-> $past(halves_q) >= $past(dly.ldo2))
        else $error("ldo2 started before its delay");
    chk_run_needs_pin: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !pin_q |=> run_q == 4'h0)
        else $error("rail running without the enable pin");
endmodule
`default_nettype wire

// ===== src/regulator_control_registers.sv
// control and status registers of the power management unit with its power-on sequencer
// assumes a serial front end that hands over address-matched byte events on host_byte_i
// Overview of operation
// - once the enable pin rises each rail whose output enable bit is set starts after the delay that the three-bit delay code picks from the table.
// - the output enable register holds enables for ldo2, ldo1, buck2 and buck1 at bits 6, 4, 2 and 0, all reset to one.
// - the read-only status register shows each rail's valid flag at bits 5, 4, 2 and 0 and resets to zero.
// - status bit 7 is set only when both bucks are valid and bit 6 only when both ldos are valid.
// - voltage change bits 1 and 5 pick target register one or two for buck1 and buck2 and reset to zero.
// - voltage change bits 0 and 4 hold the buck voltage at zero and ramp to the chosen target at one, reset zero.
// - buck1 target code zero means external control, codes 1 to 25 give 0.80 V to 2.00 V in 50 mV steps, above is 2.00 V.
// - a write frame carries the register byte then data, and a read returns the register that the last write pointed at.
`timescale 1ns/100ps
`default_nettype none
module regulator_control_registers #(
    parameter int unsigned HALF_MS_CYCLES = pmu_regs_pkg::HALF_MS_CYCLES
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // host byte port
    input wire pmu_regs_pkg::host_byte_t host_byte_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    // power sequencing
    input wire logic enable_pin_i,
    input wire pmu_regs_pkg::rail_set_t rail_ok_i,
    output pmu_regs_pkg::rail_set_t rail_run_o,
    // buck voltage control
    output logic first_switcher_target_select_o,
    output logic first_switcher_ramp_command_o,
    output logic second_switcher_target_select_o,
    output logic second_switcher_ramp_command_o,
    output logic [11:0] first_switcher_target_mv_o,
    output logic first_switcher_ext_ctrl_o
);
    pmu_regs_pkg::bus_phase_t phase_q, phase_d;
    logic [7:0] ptr_q, ptr_d;
    logic wr_en;

    logic [7:0] sys_ctrl_q, sys_ctrl_d;
    logic [7:0] out_en_q, out_en_d;
    logic [7:0] status_q, status_d;
    logic [7:0] vchg_q, vchg_d;
    logic [7:0] b1_tv1_q, b1_tv1_d;
    logic [7:0] rd_data_q, rd_data_d;
    logic rd_valid_q, rd_valid_d;
    logic [11:0] mv_q, mv_d;
    logic ext_q, ext_d;
    logic [7:0] rd_mux;
    pmu_regs_pkg::rail_set_t rail_en;

    // byte framing: first byte of a write frame is the pointer, later bytes are data
    always_comb begin
        phase_d = phase_q;
        ptr_d = ptr_q;
        wr_en = 1'b0;
        // a byte arriving with frame_start is dropped; the new frame owns that cycle
        if (host_byte_i.frame_start) begin
            phase_d = pmu_regs_pkg::POINTER_PHASE;
        end else if (host_byte_i.byte_valid) begin
            unique case (phase_q)
                pmu_regs_pkg::IDLE_PHASE: begin
                end
                pmu_regs_pkg::POINTER_PHASE: begin
                    ptr_d = host_byte_i.data;
                    phase_d = pmu_regs_pkg::DATA_PHASE;
                end
                pmu_regs_pkg::DATA_PHASE: begin
                    wr_en = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            phase_q <= pmu_regs_pkg::IDLE_PHASE;
            ptr_q <= 8'h00;
        end else begin
            phase_q <= phase_d;
            ptr_q <= ptr_d;
        end
    end

    // register file; no auto-increment, repeated data bytes rewrite the same register
    always_comb begin
        sys_ctrl_d = sys_ctrl_q;
        out_en_d = out_en_q;
        vchg_d = vchg_q;
        b1_tv1_d = b1_tv1_q;
        if (wr_en) begin
            case (ptr_q)
                pmu_regs_pkg::SYS_CTRL_ADDR: sys_ctrl_d = host_byte_i.data & pmu_regs_pkg::SYS_CTRL_MASK;
                pmu_regs_pkg::OUT_EN_ADDR: out_en_d = host_byte_i.data & pmu_regs_pkg::OUT_EN_MASK;
                pmu_regs_pkg::VCHG_ADDR: vchg_d = host_byte_i.data & pmu_regs_pkg::VCHG_MASK;
                pmu_regs_pkg::B1_TV1_ADDR: b1_tv1_d = host_byte_i.data & pmu_regs_pkg::B1_TV1_MASK;
                default: begin
                end
            endcase
        end
        status_d = 8'h00;
        status_d[pmu_regs_pkg::ST_LDO2] = rail_ok_i.ldo2;
        status_d[pmu_regs_pkg::ST_LDO1] = rail_ok_i.ldo1;
        status_d[pmu_regs_pkg::ST_BUCK2] = rail_ok_i.buck2;
        status_d[pmu_regs_pkg::ST_BUCK1] = rail_ok_i.buck1;
        status_d[pmu_regs_pkg::ST_BUCKS] = rail_ok_i.buck2 && rail_ok_i.buck1;
        status_d[pmu_regs_pkg::ST_LDOS] = rail_ok_i.ldo2 && rail_ok_i.ldo1;
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sys_ctrl_q <= pmu_regs_pkg::SYS_CTRL_RESET;
            out_en_q <= pmu_regs_pkg::OUT_EN_RESET;
            status_q <= pmu_regs_pkg::STATUS_RESET;
            vchg_q <= pmu_regs_pkg::VCHG_RESET;
            b1_tv1_q <= pmu_regs_pkg::B1_TV1_RESET;
        end else begin
            sys_ctrl_q <= sys_ctrl_d;
            out_en_q <= out_en_d;
            status_q <= status_d;
            vchg_q <= vchg_d;
            b1_tv1_q <= b1_tv1_d;
        end
    end

    // read path and buck1 voltage decode
    always_comb begin
        case (ptr_q)
            pmu_regs_pkg::SYS_CTRL_ADDR: rd_mux = sys_ctrl_q | pmu_regs_pkg::SYS_CTRL_FIXED;
            pmu_regs_pkg::OUT_EN_ADDR: rd_mux = out_en_q;
            pmu_regs_pkg::OUT_STATUS_ADDR: rd_mux = status_q;
            pmu_regs_pkg::VCHG_ADDR: rd_mux = vchg_q;
            pmu_regs_pkg::B1_TV1_ADDR: rd_mux = b1_tv1_q;
            default: rd_mux = 8'h00;
        endcase
        rd_valid_d = host_byte_i.read_req;
        rd_data_d = host_byte_i.read_req ? rd_mux : rd_data_q;
        mv_d = pmu_regs_pkg::code_to_mv(b1_tv1_q[4:0]);
        ext_d = b1_tv1_q[4:0] == 5'h00;
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'b0;
            mv_q <= 12'h000;
            ext_q <= 1'b0;
        end else begin
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            mv_q <= mv_d;
            ext_q <= ext_d;
        end
    end

    assign rail_en.ldo2 = out_en_q[pmu_regs_pkg::EN_LDO2];
    assign rail_en.ldo1 = out_en_q[pmu_regs_pkg::EN_LDO1];
    assign rail_en.buck2 = out_en_q[pmu_regs_pkg::EN_BUCK2];
    assign rail_en.buck1 = out_en_q[pmu_regs_pkg::EN_BUCK1];

    power_on_sequencer #(
        .HALF_MS_CYCLES(HALF_MS_CYCLES)
    ) sequencer (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .enable_pin_i(enable_pin_i),
        .delay_code_i(sys_ctrl_q[pmu_regs_pkg::DELAY_LSB +: 3]),
        .rail_enable_i(rail_en),
        .rail_run_o(rail_run_o)
    );

    assign rd_data_o = rd_data_q;
    assign rd_valid_o = rd_valid_q;
    // the analog ramp logic sees the command bits directly from their flops
    assign first_switcher_target_select_o = vchg_q[pmu_regs_pkg::VC_B1_SEL];
    assign first_switcher_ramp_command_o = vchg_q[pmu_regs_pkg::VC_B1_RAMP];
    assign second_switcher_target_select_o = vchg_q[pmu_regs_pkg::VC_B2_SEL];
    assign second_switcher_ramp_command_o = vchg_q[pmu_regs_pkg::VC_B2_RAMP];
    assign first_switcher_target_mv_o = mv_q;
    assign first_switcher_ext_ctrl_o = ext_q;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    chk_enable_write: assert property (
        wr_en && ptr_q == pmu_regs_pkg::OUT_EN_ADDR |=> rail_en == {$past(host_byte_i.data[6]),
            $past(host_byte_i.data[4]), $past(host_byte_i.data[2]), $past(host_byte_i.data[0])})
        else $error("enable bits not taken from the written byte");
    chk_status_follow: assert property (
        ##1 1'b1 |-> {status_q[5], status_q[4], status_q[2], status_q[0]} == $past(rail_ok_i)
            && status_q[3] == 1'b0 && status_q[1] == 1'b0)
        else $error("status flags do not follow rail valid inputs");
    chk_group_flags: assert property (
        status_q[7] == (status_q[2] && status_q[0]) && status_q[6] == (status_q[5] && status_q[4]))
        else $error("grouped valid flag wrong");
    chk_select_write: assert property (
        wr_en && ptr_q == pmu_regs_pkg::VCHG_ADDR |=> first_switcher_target_select_o
            == $past(host_byte_i.data[1]) && second_switcher_target_select_o == $past(host_byte_i.data[5]))
        else $error("target select bits not written");
    chk_ramp_hold: assert property (
        !wr_en |=> $stable(first_switcher_ramp_command_o) && $stable(second_switcher_ramp_command_o))
        else $error("ramp command changed without a write");
    chk_target_map: assert property (
        ##2 ($past(b1_tv1_q[4:0]) != 5'h00 && $past(b1_tv1_q[4:0]) <= 5'h19) |->
            first_switcher_target_mv_o == 12'(12'h2EE + 12'h032 * 12'($past(b1_tv1_q[4:0])))
            && !first_switcher_ext_ctrl_o)
        else $error("buck1 code to millivolt map wrong");
    chk_read_answer: assert property (
        host_byte_i.read_req && ptr_q == pmu_regs_pkg::OUT_STATUS_ADDR |=> rd_valid_o
            && rd_data_o == $past(status_q))
        else $error("read did not return the pointed register");
    chk_pointer_take: assert property (
        phase_q == pmu_regs_pkg::POINTER_PHASE && host_byte_i.byte_valid && !host_byte_i.frame_start
            |=> ptr_q == $past(host_byte_i.data) && phase_q == pmu_regs_pkg::DATA_PHASE)
        else $error("register byte not taken as pointer");

    cov_enable_write: cover property (wr_en && ptr_q == pmu_regs_pkg::OUT_EN_ADDR);
    cov_read_status: cover property (host_byte_i.read_req && ptr_q == pmu_regs_pkg::OUT_STATUS_ADDR);
    cov_all_valid: cover property (status_q[7] && status_q[6]);
endmodule
`default_nettype wire

// ===== tb/host_byte_model.sv
// host controller seen at byte level: write frames, pointer frames and read requests
// assumes the serial engine in front of the block has already matched the address
`timescale 1ns/100ps
`default_nettype none
module host_byte_model (
    // clock
    input wire logic core_clk_i,
    // read answer
    input wire logic [7:0] rd_data_i,
    input wire logic rd_valid_i,
    // byte events
    output pmu_regs_pkg::host_byte_t host_byte_o
);
    initial host_byte_o = '0;

    task automatic send_byte(input logic [7:0] b);
        @(posedge core_clk_i) #1;
        host_byte_o.frame_start = 1'b0;
        host_byte_o.byte_valid = 1'b1;
        host_byte_o.data = b;
    endtask

    // register byte first, then the data byte when present
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d, input logic with_data);
        @(posedge core_clk_i) #1;
        host_byte_o.frame_start = 1'b1;
        send_byte(a);
        if (with_data) begin
            send_byte(d);
        end
        @(posedge core_clk_i) #1;
        host_byte_o.byte_valid = 1'b0;
        // released data lines must not keep showing the old byte
        host_byte_o.data = ~host_byte_o.data;
    endtask

    // a read is always preceded by a pointer-only write frame
    task automatic read_reg(input logic [7:0] a, output logic [7:0] v, output logic ok);
        write_reg(a, 8'h00, 1'b0);
        @(posedge core_clk_i) #1;
        host_byte_o.read_req = 1'b1;
        @(posedge core_clk_i) #1;
        host_byte_o.read_req = 1'b0;
        ok = 1'b0;
        v = 8'h00;
        repeat (3) begin
            if (!ok) begin
                if (rd_valid_i === 1'b1) begin
                    ok = 1'b1;
                    v = rd_data_i;
                end else begin
                    @(posedge core_clk_i) #1;
                end
            end
        end
    endtask
endmodule
`default_nettype wire

// ===== tb/test_regulator_control_registers.sv
// self-checking bench of the regulator control registers with a byte-level host model
// assumes a shortened half-millisecond count so that every delay code runs in full
`timescale 1ns/100ps
`default_nettype none
module test_regulator_control_registers;
    localparam int H = 10;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic enable_pin_i = 1'b0;
    pmu_regs_pkg::rail_set_t rail_ok_i = '0;
    pmu_regs_pkg::rail_set_t rail_run_o;
    pmu_regs_pkg::host_byte_t host_byte;
    logic [7:0] rd_data;
    logic rd_valid, sel1, ramp1, sel2, ramp2, ext1, ok;
    logic [11:0] mv1;
    logic [7:0] v, d, en;
    integer seed = 97;
    integer error_cnt = 0;
    integer samples_checked = 0;
    int halves[32] = '{2, 2, 2, 2, 2, 3, 4, 4, 3, 4, 6, 12, 3, 4, 2, 2,
                       3, 4, 6, 12, 3, 3, 4, 4, 6, 4, 2, 3, 4, 6, 12, 22};
    int rise[4];
    int exp_t;

    initial forever #2.5 core_clk_i = ~core_clk_i;

    regulator_control_registers #(.HALF_MS_CYCLES(H)) uut (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .host_byte_i(host_byte),
        .rd_data_o(rd_data), .rd_valid_o(rd_valid), .enable_pin_i(enable_pin_i),
        .rail_ok_i(rail_ok_i), .rail_run_o(rail_run_o),
        .first_switcher_target_select_o(sel1), .first_switcher_ramp_command_o(ramp1),
        .second_switcher_target_select_o(sel2), .second_switcher_ramp_command_o(ramp2),
        .first_switcher_target_mv_o(mv1), .first_switcher_ext_ctrl_o(ext1));

    host_byte_model host (.core_clk_i(core_clk_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
        .host_byte_o(host_byte));

    task automatic chk(input string name, input logic [11:0] e, input logic [11:0] got);
        samples_checked++;
        if (got !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, e, got);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        host.read_reg(a, v, ok);
        chk("rd_valid", 12'h001, {11'h000, ok});
        chk("rd_data", {4'h0, e}, {4'h0, v});
    endtask

    function automatic logic [11:0] mv_of(input logic [4:0] c);
        if (c == 5'h00) return 12'h000;
        if (c > 5'h19) return 12'h7D0;
        return 12'(12'h320 + 12'h032 * 12'(c - 5'h01));
    endfunction

    function automatic logic [7:0] status_of(input pmu_regs_pkg::rail_set_t r);
        return {r.buck1 & r.buck2, r.ldo1 & r.ldo2, r.ldo2, r.ldo1, 1'b0, r.buck2, 1'b0, r.buck1};
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        error_cnt++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge core_clk_i);
        #1 reset_i = 1'b0;
        rd(8'h07, 8'h28);
        rd(8'h10, 8'h55);
        rd(8'h20, 8'h00);
        rd(8'h23, 8'h09);
        chk("mv_reset", 12'h4B0, mv1);
        host.write_reg(8'h10, 8'hFF, 1'b1);
        rd(8'h10, 8'h55);
        host.write_reg(8'h10, 8'h00, 1'b1);
        rd(8'h10, 8'h00);
        for (int i = 0; i < 16; i++) begin
            d = (8'($random(seed)) & 8'hCC) | {2'b00, i[3:2], 2'b00, i[1:0]};
            host.write_reg(8'h20, d, 1'b1);
            rd(8'h20, d & 8'h33);
            chk("vchg_out", {8'h00, i[3:0]}, {8'h00, sel2, ramp2, sel1, ramp1});
        end
        host.write_reg(8'h30, 8'hA5, 1'b1);
        rd(8'h30, 8'h00);
        for (int i = 0; i < 24; i++) begin
            @(posedge core_clk_i) #1;
            rail_ok_i = (i < 16) ? 4'(i) : 4'($random(seed));
            host.write_reg(8'h11, 8'hFF, 1'b1);
            rd(8'h11, status_of(rail_ok_i));
        end
        for (int c = 0; c < 32; c++) begin
            d = (8'($random(seed)) & 8'hE0) | 8'(c);
            host.write_reg(8'h23, d, 1'b1);
            rd(8'h23, 8'(c));
            chk("target_mv", mv_of(5'(c)), mv1);
            chk("ext_ctrl", {11'h000, c == 0}, {11'h000, ext1});
        end
        for (int c = 0; c < 8; c++) begin
            en = (c == 5) ? 8'h51 : 8'h55;
            host.write_reg(8'h07, {1'b0, 3'(c), 4'h0}, 1'b1);
            host.write_reg(8'h10, en, 1'b1);
            @(posedge core_clk_i) #1;
            enable_pin_i = 1'b1;
            rise = '{-1, -1, -1, -1};
            for (int t = 1; t < 260; t++) begin
                @(posedge core_clk_i) #1;
                for (int r = 0; r < 4; r++) begin
                    if (rail_run_o[r] === 1'b1 && rise[r] < 0) rise[r] = t;
                end
            end
            enable_pin_i = 1'b0;
            repeat (4) @(posedge core_clk_i);
            #1 chk("rails_off", 12'h000, {8'h00, rail_run_o});
            for (int r = 0; r < 4; r++) begin
                // one edge of slack for where the count is reckoned from
                exp_t = en[2 * r] ? 3 + halves[4 * c + r] * H : -1;
                samples_checked++;
                if (exp_t < 0 ? rise[r] != -1 : (rise[r] < exp_t - 1 || rise[r] > exp_t + 1)) begin
                    error_cnt++;
                    $display("[ERR] rail_start code %0d rail %0d expected %0d seen %0d", c, r, exp_t, rise[r]);
                end
            end
        end
        summarize();
    end
endmodule
`default_nettype wire
